// ---- nsm_sequencer.v ----
// Overview of operation
// - A nanoword runs at most four T-steps, then sequencing moves on.
// - Entry load puts the control-store selected entry address in the counter.
// - Field load copies the nanoword next-address field into the counter.
// - Each increment adds exactly one to the nano counter.
// - Direct jump fetches from the next-address field, counter unchanged.
// - A fetch with no prior update reads the current counter value.
// - Micro counter advance lands at step end; fetch uses the old value.
// - Branch-link on true links and branches if any masked flag is set.
// - False commit test stays in this nanoword and fetches next micro op.
// - Skip suppresses the following T-step when its test bit is one.
// - Double right shift puts the adder carry-out into the output high bit.
// - Low-bit-to-carry mode loads carry-out hold from shifter input bit 0.
// - Shifter-to-carry loads carry-out hold from shifted output low bit.
// - Multiply counter starts at 18, decrements per pass, ends at zero.
// - Product ends in the high product and multiplier registers.
// - Completion sets sign and zero from the 36-bit value and clears overflow and carry.
// - Completion word begins with an empty T-step before gating.
//
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "nsm_consts.vh"
module nsm_sequencer (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	output wire        busy
);
	localparam ST_IDLE = 3'h0;
	localparam ST_SEQ  = 3'h1;
	localparam ST_INIT = 3'h2;
	localparam ST_LOOP = 3'h3;
	localparam ST_DONE = 3'h4;

	reg  [2:0]            state_r;
	reg  [1:0]            tstep_r;
	reg  [`NSM_AW-1:0]    nano_program_counter_r;
	reg  [`NSM_AW-1:0]    fetch_addr_r;
	reg  [15:0]           micro_program_counter_r;
	reg  [15:0]           mpc_snap_r;
	reg  [3:0]            flag_status_word_r;
	reg  [`NSM_AW-1:0]    entry_addr_r;
	reg  [`NSM_AW-1:0]    next_address_field_r;
	reg  [8:0]            ctrl_r;
	reg  [3:0]            test_mask_r;
	reg  [15:0]           branch_target_r;
	reg  [15:0]           link_r;
	reg  [`NSM_DW-1:0]    mcand_r;
	reg  [`NSM_DW-1:0]    mplr_r;
	reg  [`NSM_DW-1:0]    prod_hi_r;
	reg  [4:0]            count_r;
	reg                   carry_out_hold_r;
	reg                   skip_pend_r;
	reg                   ph_wr_r;
	reg  [11:0]           ph_addr_r;
	reg  [31:0]           rdata_r;

	wire                  take;
	wire [`NSM_DW:0]      sum;
	wire [`NSM_DW-1:0]    alu_out;
	wire                  step_run;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_r;
	assign busy      = (state_r != ST_IDLE);
	assign take      = hsel & hready & htrans[1];

	// Add only when carry-out hold shows a 1 multiplier bit, else pass.
	assign sum     = {1'b0, prod_hi_r} +
	                 (carry_out_hold_r ? {1'b0, mcand_r} : {(`NSM_DW+1){1'b0}});
	assign alu_out = sum[`NSM_DW-1:0];
	assign step_run = ~skip_pend_r;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_wr_r   <= 1'b0;
			ph_addr_r <= 12'h000;
		end else if (hready) begin
			ph_wr_r   <= take & hwrite;
			ph_addr_r <= haddr[11:0];
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rdata_r <= 32'h00000000;
		end else if (take & ~hwrite) begin
			case (haddr[11:0])
			`NSM_ADDR_CTRL:  rdata_r <= {23'h000000, ctrl_r};
			`NSM_ADDR_STAT:  rdata_r <= {21'h000000, carry_out_hold_r,
			                 count_r, tstep_r, state_r};
			`NSM_ADDR_NPC:   rdata_r <= {23'h000000, nano_program_counter_r};
			`NSM_ADDR_MPC:   rdata_r <= {link_r, micro_program_counter_r};
			`NSM_ADDR_FLAGS: rdata_r <= {28'h0000000, flag_status_word_r};
			`NSM_ADDR_MCAND: rdata_r <= {14'h0000, mcand_r};
			`NSM_ADDR_MPLR:  rdata_r <= {14'h0000, mplr_r};
			`NSM_ADDR_PHI:   rdata_r <= {14'h0000, prod_hi_r};
			`NSM_ADDR_PLO:   rdata_r <= {14'h0000, mplr_r};
			`NSM_ADDR_FETCH: rdata_r <= {23'h000000, fetch_addr_r};
			default:         rdata_r <= 32'h00000000;
			endcase
		end
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r                 <= ST_IDLE;
			tstep_r                 <= 2'h0;
			nano_program_counter_r  <= {`NSM_AW{1'b0}};
			fetch_addr_r            <= {`NSM_AW{1'b0}};
			micro_program_counter_r <= 16'h0000;
			mpc_snap_r              <= 16'h0000;
			flag_status_word_r      <= 4'h0;
			entry_addr_r            <= {`NSM_AW{1'b0}};
			next_address_field_r    <= {`NSM_AW{1'b0}};
			ctrl_r                  <= 9'h000;
			test_mask_r             <= 4'h0;
			branch_target_r         <= 16'h0000;
			link_r                  <= 16'h0000;
			mcand_r                 <= {`NSM_DW{1'b0}};
			mplr_r                  <= {`NSM_DW{1'b0}};
			prod_hi_r               <= {`NSM_DW{1'b0}};
			count_r                 <= 5'h00;
			carry_out_hold_r        <= 1'b0;
			skip_pend_r             <= 1'b0;
		end else begin
			if (ph_wr_r && state_r == ST_IDLE) begin
				case (ph_addr_r)
				`NSM_ADDR_CTRL: begin
					ctrl_r  <= hwdata[8:0];
					state_r <= hwdata[`NSM_CTRL_MUL] ? ST_INIT : ST_SEQ;
					tstep_r <= 2'h0;
					mpc_snap_r <= micro_program_counter_r;
				end
				`NSM_ADDR_NPC:   nano_program_counter_r <= hwdata[`NSM_AW-1:0];
				`NSM_ADDR_MPC:   micro_program_counter_r <= hwdata[15:0];
				`NSM_ADDR_FLAGS: flag_status_word_r <= hwdata[3:0];
				`NSM_ADDR_MCAND: mcand_r <= hwdata[`NSM_DW-1:0];
				`NSM_ADDR_MPLR:  mplr_r <= hwdata[`NSM_DW-1:0];
				`NSM_ADDR_ENTRY: entry_addr_r <= hwdata[`NSM_AW-1:0];
				`NSM_ADDR_FIELD: next_address_field_r <= hwdata[`NSM_AW-1:0];
				`NSM_ADDR_TMASK: test_mask_r <= hwdata[3:0];
				`NSM_ADDR_VTGT:  branch_target_r <= hwdata[15:0];
				default: ;
				endcase
			end
			case (state_r)
			// Idle must not fall into the default branch. It would cancel the
			// state set by a command write in the same cycle.
			ST_IDLE: ;
			ST_SEQ: begin
				// One nanoword of four T-steps; updates land in step order.
				tstep_r <= tstep_r + 2'h1;
				if (tstep_r == 2'h0) begin
					// Advance lands at step end; fetch used mpc_snap_r.
					micro_program_counter_r <= micro_program_counter_r +
					                           `NSM_MPC_STEP;
					if (ctrl_r[`NSM_CTRL_INC])
						nano_program_counter_r <= nano_program_counter_r +
						                          {{(`NSM_AW-1){1'b0}}, 1'b1};
					skip_pend_r <= ctrl_r[`NSM_CTRL_SKIP] & ctrl_r[`NSM_CTRL_TBIT];
				end
				if (tstep_r == 2'h1) begin
					skip_pend_r <= 1'b0;
					if (step_run && ctrl_r[`NSM_CTRL_FIELD])
						nano_program_counter_r <= next_address_field_r;
				end
				if (tstep_r == 2'h2 && ctrl_r[`NSM_CTRL_ENTRY])
					nano_program_counter_r <= entry_addr_r;
				if (tstep_r == 2'h3) begin
					state_r <= ST_IDLE;
					if (ctrl_r[`NSM_CTRL_JUMP])
						fetch_addr_r <= next_address_field_r;
					else if (ctrl_r[`NSM_CTRL_FETCH])
						fetch_addr_r <= nano_program_counter_r;
					if (ctrl_r[`NSM_CTRL_BLT]) begin
						if (|(test_mask_r & flag_status_word_r)) begin
							link_r <= mpc_snap_r + `NSM_MPC_STEP;
							micro_program_counter_r <= branch_target_r;
						end
						// False test: stay here, next micro op at MICRO_PROGRAM_COUNTER+2.
					end
				end
			end
			ST_INIT: begin
				tstep_r <= tstep_r + 2'h1;
				if (tstep_r == 2'h2) begin
					prod_hi_r        <= {`NSM_DW{1'b0}};
					carry_out_hold_r <= mplr_r[0];
				end
				if (tstep_r == 2'h3) begin
					count_r <= `NSM_MUL_COUNT;
					state_r <= ST_LOOP;
				end
			end
			ST_LOOP: begin
				// One pass is compressed into one clock of the loop word.
				// Carry into high bit, whole pair shifts right by one.
				prod_hi_r <= {sum[`NSM_DW], alu_out[`NSM_DW-1:1]};
				mplr_r    <= {alu_out[0], mplr_r[`NSM_DW-1:1]};
				carry_out_hold_r <= mplr_r[1];
				count_r   <= count_r - 5'h01;
				if (count_r == 5'h01) begin
					state_r <= ST_DONE;
					tstep_r <= 2'h0;
				end
			end
			ST_DONE: begin
				// First step is left empty for settling.
				tstep_r <= tstep_r + 2'h1;
				if (tstep_r == 2'h1) begin
					flag_status_word_r[`NSM_FLG_SIGN]  <= prod_hi_r[`NSM_DW-1];
					flag_status_word_r[`NSM_FLG_ZERO]  <= ~|{prod_hi_r, mplr_r};
					flag_status_word_r[`NSM_FLG_OVF]   <= 1'b0;
					flag_status_word_r[`NSM_FLG_CARRY] <= 1'b0;
					state_r <= ST_IDLE;
				end
			end
			default: state_r <= ST_IDLE;
			endcase
		end
	end
endmodule

// ---- nsm_consts.vh ----
`ifndef NSM_CONSTS_VH
`define NSM_CONSTS_VH
`define NSM_AW          9
`define NSM_DW          18
`define NSM_TSTEPS      4
`define NSM_MPC_STEP    16'h0002
`define NSM_MUL_COUNT   5'h12
`define NSM_ADDR_CTRL   12'h000
`define NSM_ADDR_STAT   12'h004
`define NSM_ADDR_NPC    12'h008
`define NSM_ADDR_MPC    12'h00c
`define NSM_ADDR_FLAGS  12'h010
`define NSM_ADDR_MCAND  12'h014
`define NSM_ADDR_MPLR   12'h018
`define NSM_ADDR_PHI    12'h01c
`define NSM_ADDR_PLO    12'h020
`define NSM_ADDR_ENTRY  12'h024
`define NSM_ADDR_FIELD  12'h028
`define NSM_ADDR_UOP    12'h02c
`define NSM_ADDR_TMASK  12'h030
`define NSM_ADDR_VTGT   12'h034
`define NSM_ADDR_FETCH  12'h038
`define NSM_CTRL_ENTRY  0
`define NSM_CTRL_FIELD  1
`define NSM_CTRL_INC    2
`define NSM_CTRL_JUMP   3
`define NSM_CTRL_FETCH  4
`define NSM_CTRL_MUL    5
`define NSM_CTRL_BLT    6
`define NSM_CTRL_SKIP   7
`define NSM_CTRL_TBIT   8
`define NSM_FLG_SIGN    0
`define NSM_FLG_ZERO    1
`define NSM_FLG_OVF     2
`define NSM_FLG_CARRY   3
`endif

// ---- nsm_seq_assertions.sv ----
`timescale 1ns/1ps
module nsm_seq_assertions (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        busy
);
	logic wr_ctrl_r;
	logic mul_r;
	logic rd_take;
	assign rd_take = hsel && hready && htrans[1] && !hwrite;
	// The run kind is latched with the command so the length check knows it.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ctrl_r <= 1'b0;
			mul_r <= 1'b0;
		end else begin
			wr_ctrl_r <= hsel && hready && htrans[1] && hwrite && !busy
				&& haddr[11:0] == 12'h000;
			mul_r <= wr_ctrl_r ? hwdata[5] : mul_r;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_ready_high: assert property (hreadyout)
		else $error("hreadyout low");
	a_resp_okay: assert property (!hresp)
		else $error("hresp not okay");
	a_ctrl_starts: assert property (wr_ctrl_r && hwdata[5:0] != 6'h00 |=> busy)
		else $error("command did not start");
	a_seq_steps: assert property ($rose(busy) && !mul_r |-> busy[*4] ##1 !busy)
		else $error("nanoword not four steps");
	a_mul_passes: assert property ($rose(busy) && mul_r |-> ##23 busy ##1 !busy)
		else $error("multiply length wrong");
	a_start_cause: assert property ($rose(busy) |-> $past(wr_ctrl_r))
		else $error("busy without command");
	a_rdata_hold: assert property (!rd_take |=> $stable(hrdata))
		else $error("read data moved");
	a_unmapped_zero: assert property (rd_take && haddr[11:0] > 12'h038 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	c_mul: cover property ($rose(busy) && mul_r);
	c_mpc: cover property (rd_take && haddr[11:0] == 12'h00c);
	c_blt: cover property (wr_ctrl_r && hwdata[6]);
endmodule
bind nsm_sequencer nsm_seq_assertions nsm_seq_assertions_inst (.*);

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	wire  [31:0] hrdata;
	wire         hreadyout;
	wire         hresp;
	wire         busy;
	int          failures = 0;
	int          n_checks = 0;
	logic [31:0] q;
	always #2.5 hclk = ~hclk;
	// A lone slave: its own ready is the bus ready.
	nsm_sequencer nsm_sequencer_inst (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.busy(busy));
	task automatic ck(input string n, input logic [31:0] e,
		input logic [31:0] s);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic rc(input string n, input logic [11:0] a,
		input logic [31:0] e);
		logic [31:0] v;
		bus(1'b0, a, 32'h0, v);
		ck(n, e, v);
	endtask
	// Polls busy so no command word lands while one is running.
	task automatic go(input logic [31:0] c);
		int i;
		bus(1'b1, 12'h000, c, q);
		@(posedge hclk);
		for (i = 0; i < 64 && busy !== 1'b0; i++) @(posedge hclk);
		ck("busy", 32'h0, {31'h0, busy});
	endtask
	task automatic s_reset;
		rc("npc", 12'h008, 32'h0);
		rc("flags", 12'h010, 32'h0);
		bus(1'b1, 12'h03c, 32'h5a5a, q);
		rc("unmapped", 12'h03c, 32'h0);
	endtask
	task automatic s_counter;
		bus(1'b1, 12'h024, 32'h005, q);
		bus(1'b1, 12'h028, 32'h0a0, q);
		go(32'h014);
		rc("npc", 12'h008, 32'h001);
		rc("fetch", 12'h038, 32'h001);
		go(32'h012);
		rc("npc", 12'h008, 32'h0a0);
		bus(1'b1, 12'h028, 32'h033, q);
		go(32'h018);
		rc("fetch", 12'h038, 32'h033);
		rc("npc", 12'h008, 32'h0a0);
		go(32'h010);
		rc("fetch", 12'h038, 32'h0a0);
		go(32'h017);
		rc("npc", 12'h008, 32'h005);
		go(32'h192);
		rc("npc", 12'h008, 32'h005);
		go(32'h092);
		rc("npc", 12'h008, 32'h033);
		bus(1'b0, 12'h00c, 32'h0, q);
		ck("mpc", 32'h000e, {16'h0, q[15:0]});
	endtask
	task automatic s_mul;
		bus(1'b1, 12'h014, 32'h3ffff, q);
		bus(1'b1, 12'h018, 32'h3ffff, q);
		go(32'h020);
		rc("phi", 12'h01c, 32'h3fffe);
		rc("mplr", 12'h018, 32'h00001);
		rc("flags", 12'h010, 32'h1);
		bus(1'b1, 12'h014, 32'h0, q);
		bus(1'b1, 12'h018, 32'h12345, q);
		go(32'h020);
		rc("flags", 12'h010, 32'h2);
	endtask
	task automatic s_branch;
		logic [31:0] m;
		bus(1'b1, 12'h030, 32'h1, q);
		bus(1'b1, 12'h034, 32'h100, q);
		bus(1'b0, 12'h00c, 32'h0, m);
		go(32'h040);
		bus(1'b0, 12'h00c, 32'h0, q);
		ck("mpc", {16'h0, m[15:0] + 16'h2}, {16'h0, q[15:0]});
		bus(1'b1, 12'h030, 32'h2, q);
		go(32'h040);
		bus(1'b0, 12'h00c, 32'h0, q);
		ck("mpc", 32'h0100, {16'h0, q[15:0]});
		ck("link", {16'h0, m[15:0] + 16'h4}, {16'h0, q[31:16]});
	endtask
	task automatic end_of_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge hclk);
		failures++;
		end_of_test;
	end
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		s_reset;
		s_counter;
		s_mul;
		s_branch;
		end_of_test;
	end
endmodule
